// ==== array_move_search_engine.sv ====
// array move and array search engine over a word-wide data memory
`timescale 1ns/1ps
module array_move_search_engine
  import amse_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              op_sel,
  input  wire logic [2:0]        elem_type,
  input  wire logic [2:0]        cmp_mode,
  input  wire logic [ADDR_W-1:0] source_start,
  input  wire logic [BIT_W-1:0]  source_bit,
  input  wire logic [IDX_W-1:0]  source_index,
  input  wire logic [ADDR_W-1:0] dest_start,
  input  wire logic [BIT_W-1:0]  dest_bit,
  input  wire logic [IDX_W-1:0]  dest_index,
  input  wire logic [IDX_W-1:0]  element_count,
  input  wire logic [IDX_W-1:0]  length,
  input  wire logic [ADDR_W-1:0] search_array_start,
  input  wire logic [IDX_W-1:0]  search_index,
  input  wire logic [DATA_W-1:0] search_key,
  output logic                   busy,
  output logic                   done,
  output logic                   move_ok,
  output logic                   found_flag,
  output logic      [IDX_W-1:0]  position,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic      [WORD_W-1:0] mem_wdata,
  input  wire logic [WORD_W-1:0] mem_rdata
);
  typedef enum logic [3:0] {
    IDLE    = 4'h0,                      // waiting for enable
    MV_RD   = 4'h1,                      // issue source low read
    MV_RDH  = 4'h2,                      // issue source high read
    MV_RDD  = 4'h3,                      // issue destination read (bits)
    MV_WAIT = 4'h4,                      // let reads return
    MV_WR   = 4'h5,                      // write low / merged word
    MV_WRH  = 4'h6,                      // write high word
    SR_RD   = 4'h7,                      // issue element low read
    SR_RDH  = 4'h8,                      // issue element high read
    SR_WAIT = 4'h9,                      // let reads return
    SR_CMP  = 4'hA,                      // compare and step
    FIN     = 4'hB                       // one-cycle completion
  } state_type;

  state_type         state_r;            // sequencer state
  state_type         state_nxt;          // next sequencer state
  logic [2:0]        type_r;             // latched element type
  logic [2:0]        mode_r;             // latched comparison mode
  logic [ADDR_W-1:0] src_start_r;        // source or search array start
  logic [BIT_W-1:0]  src_bit_r;          // source start bit
  logic [ADDR_W-1:0] dst_start_r;        // destination start
  logic [BIT_W-1:0]  dst_bit_r;          // destination start bit
  logic [IDX_W-1:0]  src_idx_r;          // zero-based current source index
  logic [IDX_W-1:0]  dst_idx_r;          // zero-based current dest index
  logic [IDX_W-1:0]  left_r;             // elements still to move
  logic [IDX_W-1:0]  len_r;              // latched array length
  logic [DATA_W-1:0] key_r;              // latched search key
  logic [DATA_W-1:0] buf_r;              // element read from memory
  logic [WORD_W-1:0] dword_r;            // destination word for bit merge
  logic              rd_q;               // read strobe one cycle later
  logic [1:0]        tag_r;              // tag of the read on the bus
  logic [1:0]        tag_q;              // tag of the returning word
  logic [ADDR_W-1:0] src_waddr;          // source element word address
  logic [BIT_W-1:0]  src_bpos;           // source element bit
  logic [ADDR_W-1:0] dst_waddr;          // destination element word address
  logic [BIT_W-1:0]  dst_bpos;           // destination element bit
  logic              hit;                // comparator result
  logic              start;              // request taken this cycle
  logic              move_fits;          // bounds check passes
  logic [IDX_W+1:0]  src_end;            // count + source_index - 1
  logic [IDX_W+1:0]  dst_end;            // count + dest_index - 1
  logic              idx_bad;            // search index out of range
  logic              last_elem;          // current element is the last one
  logic [WORD_W-1:0] merged;             // destination word with new bit

  // source / search element address
  elem_addr u_src_addr (
    .base_word (src_start_r),
    .base_bit  (src_bit_r),
    .elem_idx  (src_idx_r),
    .elem_type (type_r),
    .word_addr (src_waddr),
    .bit_pos   (src_bpos)
  );

  // destination element address
  elem_addr u_dst_addr (
    .base_word (dst_start_r),
    .base_bit  (dst_bit_r),
    .elem_idx  (dst_idx_r),
    .elem_type (type_r),
    .word_addr (dst_waddr),
    .bit_pos   (dst_bpos)
  );

  // search comparator
  elem_compare u_cmp (
    .elem      (buf_r),
    .key       (key_r),
    .elem_type (type_r),
    .cmp_mode  (mode_r),
    .hit       (hit)
  );

  // request decode and bounds checks on the live operands
  always_comb begin
    start = (state_r == IDLE) && enable;
    // one-based ends, wide enough that nothing wraps
    src_end = (IDX_W+2)'(element_count) + (IDX_W+2)'(source_index)
              - (IDX_W+2)'(IDX_ONE);
    dst_end = (IDX_W+2)'(element_count) + (IDX_W+2)'(dest_index)
              - (IDX_W+2)'(IDX_ONE);
    // index zero would address before the array start
    move_fits = (src_end <= (IDX_W+2)'(length))
              && (dst_end <= (IDX_W+2)'(length))
              && (source_index != '0) && (dest_index != '0);
    // negative or past-the-end start index
    idx_bad = search_index[IDX_W-1] || (search_index >= length);
    // current element is the array's last one
    last_elem = ((src_idx_r + IDX_ONE) >= len_r);
  end

  // destination word with the moved bit dropped in
  always_comb begin
    merged = dword_r;
    merged[dst_bpos] = buf_r[src_bpos];
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IDLE: begin
        if (start) begin
          if (op_sel == OP_SEARCH) begin
            // bit type is not searchable; empty array never hits
            if (elem_type == T_BOOL || length == '0) begin
              state_nxt = FIN;
            end else begin
              state_nxt = SR_RD;
            end
          end else if (move_fits && element_count != '0) begin
            state_nxt = MV_RD;
          end else begin
            state_nxt = FIN;
          end
        end
      end
      MV_RD: begin
        if (type_r == T_SIGNED_DOUBLE_INTEGER) begin
          state_nxt = MV_RDH;
        end else if (type_r == T_BOOL) begin
          state_nxt = MV_RDD;
        end else begin
          state_nxt = MV_WAIT;
        end
      end
      MV_RDH:  state_nxt = MV_WAIT;
      MV_RDD:  state_nxt = MV_WAIT;
      MV_WAIT: begin
        // nothing may be written until every read has landed
        if (!mem_rd && !rd_q) begin
          state_nxt = MV_WR;
        end
      end
      // signed_double_integer takes a second write; the last element ends the pass
      MV_WR:   state_nxt = (type_r == T_SIGNED_DOUBLE_INTEGER) ? MV_WRH
                         : (left_r == IDX_ONE) ? FIN : MV_RD;
      MV_WRH:  state_nxt = (left_r == IDX_ONE) ? FIN : MV_RD;
      SR_RD:   state_nxt = (type_r == T_SIGNED_DOUBLE_INTEGER) ? SR_RDH : SR_WAIT;
      SR_RDH:  state_nxt = SR_WAIT;
      SR_WAIT: begin
        if (!mem_rd && !rd_q) begin
          state_nxt = SR_CMP;
        end
      end
      SR_CMP: begin
        // first hit or last element ends the scan
        if (hit || last_elem) begin
          state_nxt = FIN;
        end else begin
          state_nxt = SR_RD;
        end
      end
      FIN:     state_nxt = IDLE;
      default: state_nxt = IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // operands latched when a request is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      type_r      <= T_INT;
      mode_r      <= C_EQ;
      src_start_r <= '0;
      src_bit_r   <= '0;
      dst_start_r <= '0;
      dst_bit_r   <= '0;
      len_r       <= '0;
      key_r       <= '0;
    end else if (start) begin
      type_r <= elem_type;
      mode_r <= cmp_mode;
      len_r  <= length;
      key_r  <= search_key;
      // search reuses the source address path, start bit zero
      if (op_sel == OP_SEARCH) begin
        src_start_r <= search_array_start;
        src_bit_r   <= '0;
      end else begin
        src_start_r <= source_start;
        src_bit_r   <= source_bit;
      end
      dst_start_r <= dest_start;
      dst_bit_r   <= dest_bit;
    end
  end

  // element indices and remaining count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_idx_r <= '0;
      dst_idx_r <= '0;
      left_r    <= '0;
    end else if (start) begin
      if (op_sel == OP_SEARCH) begin
        src_idx_r <= idx_bad ? '0 : search_index;
      end else begin
        src_idx_r <= source_index - IDX_ONE;
      end
      dst_idx_r <= dest_index - IDX_ONE;
      left_r    <= element_count;
    end else if ((state_r == MV_WR && type_r != T_SIGNED_DOUBLE_INTEGER)
                 || state_r == MV_WRH) begin
      // step after the element's last write
      src_idx_r <= src_idx_r + IDX_ONE;
      dst_idx_r <= dst_idx_r + IDX_ONE;
      left_r    <= left_r - IDX_ONE;
    end else if (state_r == SR_CMP && !hit) begin
      src_idx_r <= src_idx_r + IDX_ONE;
    end
  end

  // memory strobes, address and write data, all registered
  // one access per cycle, never a read and write together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rd    <= 1'h0;
      mem_wr    <= 1'h0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      tag_r     <= TAG_LO;
    end else begin
      mem_rd <= 1'h0;
      mem_wr <= 1'h0;
      case (state_r)
        MV_RD, SR_RD: begin
          mem_rd   <= 1'h1;
          mem_addr <= src_waddr;
          tag_r    <= TAG_LO;
        end
        MV_RDH, SR_RDH: begin
          mem_rd   <= 1'h1;
          mem_addr <= src_waddr + ADDR_W'(IDX_ONE);
          tag_r    <= TAG_HI;
        end
        MV_RDD: begin
          // bit moves merge into the destination word
          mem_rd   <= 1'h1;
          mem_addr <= dst_waddr;
          tag_r    <= TAG_DST;
        end
        MV_WR: begin
          mem_wr   <= 1'h1;
          mem_addr <= dst_waddr;
          case (type_r)
            T_BOOL:  mem_wdata <= merged;
            T_BYTE:  mem_wdata <= WORD_W'(buf_r[BYTE_W-1:0]);
            default: mem_wdata <= buf_r[WORD_W-1:0];
          endcase
        end
        MV_WRH: begin
          mem_wr    <= 1'h1;
          mem_addr  <= dst_waddr + ADDR_W'(IDX_ONE);
          mem_wdata <= buf_r[DATA_W-1:WORD_W];
        end
        default: mem_addr <= mem_addr;
      endcase
    end
  end

  // read return pipeline: data stand the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q    <= 1'h0;
      tag_q   <= TAG_LO;
      buf_r   <= '0;
      dword_r <= '0;
    end else begin
      rd_q  <= mem_rd;
      tag_q <= tag_r;
      if (rd_q) begin
        case (tag_q)
          TAG_LO: begin
            // single-word types leave the high half clear
            buf_r <= DATA_W'(mem_rdata);
          end
          TAG_HI:  buf_r[DATA_W-1:WORD_W] <= mem_rdata;
          TAG_DST: dword_r <= mem_rdata;
          default: buf_r <= buf_r;
        endcase
      end
    end
  end

  // move result; enable low clears ok at the next clock edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      move_ok <= 1'h0;
    end else if (!enable) begin
      move_ok <= 1'h0;
    end else if (start && op_sel == OP_MOVE) begin
      // bit type passes; only the bounds decide
      move_ok <= move_fits;
    end
  end

  // search result, held until the next search ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      found_flag <= 1'h0;
      position   <= '0;
    end else if (state_r == SR_CMP && hit) begin
      found_flag <= 1'h1;
      position   <= src_idx_r + IDX_ONE;
    end else if ((state_r == SR_CMP && last_elem)
                 || (start && op_sel == OP_SEARCH
                     && (elem_type == T_BOOL || length == '0))) begin
      found_flag <= 1'h0;
      position   <= '0;
    end
  end

  // status strobes
  always_comb begin
    busy = (state_r != IDLE);
    done = (state_r == FIN);
  end
endmodule

// ==== amse_pkg.sv ====
// shared constants for the array move and search engine
// How it works
// - int, signed_double_integer, byte, word both ops; bits move-only
// - move copies count elements source to destination
// - bit arrays start at the start bit of start word
// - bit starts may sit at any bit
// - one-based move indices, zero-based search index, never touch outside arrays
// - ok fails when disabled, a move index is zero or count overruns
// - six comparisons of element against search key
// - search starts at array start plus index
// - stop at first hit or after last element
// - hit sets found flag, one-based position
// - miss clears found flag, position zero
// - out-of-range search index replaced by zero
// - nonzero positions run from one to length
package amse_pkg;
  localparam int ADDR_W = 16;            // data memory word address width
  localparam int IDX_W  = 16;            // index, count and length width
  localparam int WORD_W = 16;            // data memory word width
  localparam int DATA_W = 32;            // widest element (double integer)
  localparam int BYTE_W = 8;             // byte element width
  localparam int BIT_W  = 4;             // bit position inside a word
  // element type codes
  localparam logic [2:0] T_INT  = 3'h0;  // signed 16-bit integer
  localparam logic [2:0] T_SIGNED_DOUBLE_INTEGER = 3'h1;  // signed_double_integer
  localparam logic [2:0] T_BOOL = 3'h2;  // single bit
  localparam logic [2:0] T_BYTE = 3'h3;  // unsigned byte
  localparam logic [2:0] T_WORD = 3'h4;  // unsigned word
  // comparison mode codes
  localparam logic [2:0] C_EQ = 3'h0;
  localparam logic [2:0] C_NE = 3'h1;
  localparam logic [2:0] C_GT = 3'h2;
  localparam logic [2:0] C_GE = 3'h3;
  localparam logic [2:0] C_LT = 3'h4;
  localparam logic [2:0] C_LE = 3'h5;
  // operation select
  localparam logic OP_MOVE   = 1'h0;
  localparam logic OP_SEARCH = 1'h1;
  // tag telling where a returning read word lands
  localparam logic [1:0] TAG_LO  = 2'h0; // low half of element buffer
  localparam logic [1:0] TAG_HI  = 2'h1; // high half of element buffer
  localparam logic [1:0] TAG_DST = 2'h2; // destination word for bit merge
  localparam logic [IDX_W-1:0] IDX_ONE = 16'h0001;
endpackage

// ==== elem_addr.sv ====
// element index to memory word address and bit position
`timescale 1ns/1ps
module elem_addr
  import amse_pkg::*;
(
  input  wire logic [ADDR_W-1:0] base_word,
  input  wire logic [BIT_W-1:0]  base_bit,
  input  wire logic [IDX_W-1:0]  elem_idx,
  input  wire logic [2:0]        elem_type,
  output logic      [ADDR_W-1:0] word_addr,
  output logic      [BIT_W-1:0]  bit_pos
);
  logic [IDX_W:0] bit_sum;               // absolute bit offset from start

  // combinational address arithmetic, zero-based element index
  always_comb begin
    bit_sum = {1'h0, elem_idx} + (IDX_W+1)'(base_bit);
    bit_pos = '0;
    case (elem_type)
      T_BOOL: begin
        // element one is the start bit of the start word, then upward
        // start bit is free, no byte alignment needed
        word_addr = base_word + ADDR_W'(bit_sum >> BIT_W);
        bit_pos   = bit_sum[BIT_W-1:0];
      end
      T_SIGNED_DOUBLE_INTEGER: begin
        // two words per element, low word first
        word_addr = base_word + ADDR_W'({elem_idx, 1'h0});
      end
      default: begin
        // int, word and byte each take one word
        word_addr = base_word + ADDR_W'(elem_idx);
      end
    endcase
  end
endmodule

// ==== elem_compare.sv ====
// search comparator: one element against the key
`timescale 1ns/1ps
module elem_compare
  import amse_pkg::*;
(
  input  wire logic [DATA_W-1:0] elem,
  input  wire logic [DATA_W-1:0] key,
  input  wire logic [2:0]        elem_type,
  input  wire logic [2:0]        cmp_mode,
  output logic                   hit
);
  logic signed [DATA_W:0] a_v;           // element, extended one bit
  logic signed [DATA_W:0] k_v;           // key, extended the same way

  // extend both operands so one signed compare serves every type
  always_comb begin
    case (elem_type)
      T_INT: begin
        a_v = {{(DATA_W+1-WORD_W){elem[WORD_W-1]}}, elem[WORD_W-1:0]};
        k_v = {{(DATA_W+1-WORD_W){key[WORD_W-1]}}, key[WORD_W-1:0]};
      end
      T_SIGNED_DOUBLE_INTEGER: begin
        a_v = {elem[DATA_W-1], elem};
        k_v = {key[DATA_W-1], key};
      end
      T_BYTE: begin
        a_v = {{(DATA_W+1-BYTE_W){1'h0}}, elem[BYTE_W-1:0]};
        k_v = {{(DATA_W+1-BYTE_W){1'h0}}, key[BYTE_W-1:0]};
      end
      default: begin
        a_v = {{(DATA_W+1-WORD_W){1'h0}}, elem[WORD_W-1:0]};
        k_v = {{(DATA_W+1-WORD_W){1'h0}}, key[WORD_W-1:0]};
      end
    endcase
  end

  // six comparison modes; unknown code never hits
  always_comb begin
    case (cmp_mode)
      C_EQ:    hit = (a_v == k_v);
      C_NE:    hit = (a_v != k_v);
      C_GT:    hit = (a_v >  k_v);
      C_GE:    hit = (a_v >= k_v);
      C_LT:    hit = (a_v <  k_v);
      C_LE:    hit = (a_v <= k_v);
      default: hit = 1'h0;
    endcase
  end
endmodule

// ==== mem_model.sv ====
// word-wide data memory on the far side of the engine
`timescale 1ns/1ps
module mem_model
  import amse_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic [WORD_W-1:0] mem_wdata,
  output logic      [WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] mem [0:255]; // only the low address byte decodes
  initial mem_rdata = 16'h0000;
  // one access a cycle, read data valid only in the following cycle
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
    // stale data flips so a late capture cannot pass by luck
    mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
  end
endmodule

// ==== array_move_search_engine_monitor.sv ====
// port checker for the array move and search engine
`timescale 1ns/1ps
module array_move_search_engine_monitor
  import amse_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              enable,
  input wire logic              op_sel,
  input wire logic [2:0]        elem_type,
  input wire logic [ADDR_W-1:0] dest_start,
  input wire logic [IDX_W-1:0]  source_index,
  input wire logic [IDX_W-1:0]  dest_index,
  input wire logic [IDX_W-1:0]  element_count,
  input wire logic [IDX_W-1:0]  length,
  input wire logic [IDX_W-1:0]  search_index,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              move_ok,
  input wire logic              found_flag,
  input wire logic [IDX_W-1:0]  position,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_rd,
  input wire logic              mem_wr
);
  logic              take;    // request accepted at this edge
  logic              in_b;    // move operands inside both arrays
  logic              srch_r;  // pass in flight is a search
  logic              one_w_r; // move of one-word elements
  logic [IDX_W-1:0]  len_r;   // array length of the pass
  logic [IDX_W-1:0]  first_r; // first index examined
  logic [ADDR_W-1:0] lo_r;    // first destination word
  logic [ADDR_W-1:0] hi_r;    // one past the last destination word
  assign take = !busy && enable;
  // widened sums so a huge count cannot wrap back into range
  assign in_b = source_index != 16'h0000 && dest_index != 16'h0000
    && 17'(element_count) + 17'(source_index) <= 17'(length) + 17'h1
    && 17'(element_count) + 17'(dest_index) <= 17'(length) + 17'h1;
  // operands seen at each accepted request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srch_r  <= 1'b0;
      one_w_r <= 1'b0;
    end else if (take) begin
      srch_r  <= op_sel == OP_SEARCH;
      one_w_r <= op_sel == OP_MOVE
        && elem_type inside {T_INT, T_BYTE, T_WORD};
      len_r   <= length;
      // negative indices wrap above any legal length
      first_r <= search_index >= length ? 16'h0000 : search_index;
      lo_r    <= dest_start + dest_index - 16'h0001;
      hi_r    <= dest_start + dest_index - 16'h0001 + element_count;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a move request and its bounds verdict
  sequence s_move;
    take && op_sel == OP_MOVE;
  endsequence
  sequence s_bad;
    s_move ##0 !in_b;
  endsequence
  sequence s_good;
    s_move ##0 in_b;
  endsequence
  access_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  done_pulse_a: assert property (done |=> !done && !busy)
    else $error("done longer than one cycle");
  bad_move_a: assert property (s_bad |=> done && !move_ok)
    else $error("out of bounds move not refused at once");
  bad_quiet_a: assert property (s_bad |-> ##2 !mem_rd && !mem_wr)
    else $error("refused move touched memory");
  good_move_a: assert property (s_good |=> move_ok)
    else $error("move within bounds not ok");
  ok_drop_a: assert property (!enable |=> !move_ok)
    else $error("ok stands with enable low");
  miss_zero_a: assert property
    (done && srch_r && !found_flag |-> position == 16'h0000)
    else $error("miss with nonzero position");
  hit_range_a: assert property
    (done && srch_r && found_flag |-> position > first_r && position <= len_r)
    else $error("hit position outside searched range");
  wr_window_a: assert property
    (mem_wr && one_w_r |-> mem_addr >= lo_r && mem_addr < hi_r)
    else $error("write outside destination elements");
  read_only_a: assert property (busy && srch_r |-> !mem_wr)
    else $error("search wrote memory");
endmodule
bind array_move_search_engine array_move_search_engine_monitor
  array_move_search_engine_monitor_i (.clk, .rst_n, .enable, .op_sel,
  .elem_type, .dest_start, .source_index, .dest_index, .element_count,
  .length, .search_index, .busy, .done, .move_ok, .found_flag, .position,
  .mem_addr, .mem_rd, .mem_wr);

// ==== test_array_move_search_engine.sv ====
// self-checking testbench for the array move and search engine
`timescale 1ns/1ps
module test_array_move_search_engine
  import amse_pkg::*;
  ;
  localparam int SRC  = 16;  // source array word
  localparam int DST  = 48;  // destination array word
  localparam int SRCH = 96;  // search array word
  localparam int SLEN = 8;   // search array length
  // signed contents, repeats and negatives for every comparison
  localparam logic [15:0] SARR [0:7] = '{16'h0005, 16'hFFFD, 16'h0007,
    16'h0007, 16'h0000, 16'h0009, 16'hFFFD, 16'h0002};
  // start index and key pairs: plain, mid, too big, negative, last
  localparam logic [15:0] IDX [0:4] = '{16'h0000, 16'h0003, 16'h0008,
    16'hFFFF, 16'h0007};
  localparam logic [15:0] KEY [0:4] = '{16'h0007, 16'hFFFD, 16'h0002,
    16'h0064, 16'h0009};
  logic              clk = 1'b0;
  logic              rst_n, enable, op_sel;
  logic [2:0]        elem_type, cmp_mode;
  logic [ADDR_W-1:0] source_start, dest_start, search_array_start;
  logic [BIT_W-1:0]  source_bit, dest_bit;
  logic [IDX_W-1:0]  source_index, dest_index, element_count, length;
  logic [IDX_W-1:0]  search_index, position, got_pos;
  logic [DATA_W-1:0] search_key;
  logic              busy, done, move_ok, found_flag, got_ok, got_found;
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_rd, mem_wr;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  int                fails = 0;
  int                n_compared = 0;
  int                cycles = 0;
  array_move_search_engine array_move_search_engine_i (.clk, .rst_n,
    .enable, .op_sel, .elem_type, .cmp_mode, .source_start, .source_bit,
    .source_index, .dest_start, .dest_bit, .dest_index, .element_count,
    .length, .search_array_start, .search_index, .search_key, .busy, .done,
    .move_ok, .found_flag, .position, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata);
  mem_model mem_model_i (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata);
  always #5 clk = ~clk;
  // cut a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // flags widened so an unknown still fails
  task automatic chk_flag(input logic got, exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  // one pass: raise enable, wait for done, drop enable a cycle later
  task automatic go();
    int n;
    n = 0;
    enable <= 1'b1;
    @(negedge clk);
    while (done !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n == 500) begin
      fails++;
      wrap_up();
    end
    got_ok    = move_ok;
    got_found = found_flag;
    got_pos   = position;
    @(posedge clk);
    enable <= 1'b0;
    @(posedge clk);
  endtask
  // expected position of a 16-bit search; word compares unsigned
  function automatic logic [15:0] ref_pos(input logic [15:0] idx,
    input logic [2:0] m, t, input logic [15:0] key);
    int   v, k;
    logic h;
    k = t == T_WORD ? int'(key) : $signed(key);
    if (t == T_BOOL) return 16'h0000;
    // negative values wrap above the length as well
    if (idx >= SLEN) idx = 16'h0000;
    for (int i = idx; i < SLEN; i++) begin
      v = t == T_WORD ? int'(SARR[i]) : $signed(SARR[i]);
      case (m)
        C_EQ: h = v == k;
        C_NE: h = v != k;
        C_GT: h = v > k;
        C_GE: h = v >= k;
        C_LT: h = v < k;
        default: h = v <= k;
      endcase
      if (h) return 16'(i + 1);
    end
    return 16'h0000;
  endfunction
  task automatic srch(input logic [2:0] t, m, input logic [15:0] idx, key);
    logic [15:0] e;
    e = ref_pos(idx, m, t, key);
    op_sel       <= OP_SEARCH;
    elem_type    <= t;
    cmp_mode     <= m;
    search_index <= idx;
    search_key   <= {16'h0000, key};
    go();
    chk_flag(got_found, e != 16'h0000);
    chk_word(got_pos, e);
  endtask
  // move, then compare the whole destination area with a predicted copy
  task automatic mv(input logic [2:0] t, input int si, di, n, len, sb, db);
    logic [15:0] e [0:255];
    int          w, s, d;
    logic        okx;
    e = mem_model_i.mem;
    w = t == T_SIGNED_DOUBLE_INTEGER ? 2 : 1;
    okx = si > 0 && di > 0 && n + si - 1 <= len && n + di - 1 <= len;
    for (int k = 0; okx && k < n * w; k++) begin
      s = (si - 1) * w + k + sb;
      d = (di - 1) * w + k + db;
      if (t == T_BOOL)
        e[DST + d / 16][d % 16] = mem_model_i.mem[SRC + s / 16][s % 16];
      else if (t == T_BYTE)
        e[DST + d] = {8'h00, mem_model_i.mem[SRC + s][7:0]};
      else
        e[DST + d] = mem_model_i.mem[SRC + s];
    end
    op_sel        <= OP_MOVE;
    elem_type     <= t;
    source_bit    <= 4'(sb);
    dest_bit      <= 4'(db);
    source_index  <= 16'(si);
    dest_index    <= 16'(di);
    element_count <= 16'(n);
    length        <= 16'(len);
    go();
    chk_flag(got_ok, okx);
    for (int a = DST; a < DST + 32; a++)
      chk_word(mem_model_i.mem[a], e[a]);
  endtask
  initial begin
    {rst_n, enable, op_sel, elem_type, cmp_mode} = '0;
    {source_bit, dest_bit, search_key} = '0;
    {source_index, dest_index, element_count, length, search_index} = '0;
    source_start       = 16'(SRC);
    dest_start         = 16'(DST);
    search_array_start = 16'(SRCH);
    for (int a = 0; a < 256; a++)
      mem_model_i.mem[a] = 16'(a * 16'h0159 + 16'h2A3C);
    for (int i = 0; i < SLEN; i++)
      mem_model_i.mem[SRCH + i] = SARR[i];
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    mv(T_WORD, 3, 4, 5, 16, 0, 0);
    mv(T_INT, 1, 12, 5, 16, 0, 0);
    mv(T_BYTE, 2, 2, 3, 16, 0, 0);
    mv(T_SIGNED_DOUBLE_INTEGER, 2, 1, 3, 8, 0, 0);
    mv(T_BOOL, 14, 16, 5, 20, 2, 14);
    mv(T_WORD, 1, 1, 0, 16, 0, 0);
    mv(T_WORD, 1, 13, 5, 16, 0, 0);
    mv(T_WORD, 13, 1, 5, 16, 0, 0);
    mv(T_WORD, 0, 1, 2, 16, 0, 0);
    $display("move tests done");
    length    <= 16'(SLEN);
    for (int m = 0; m < 6; m++)
      for (int p = 0; p < 5; p++)
        srch(T_INT, 3'(m), IDX[p], KEY[p]);
    srch(T_WORD, C_GT, 16'h0000, 16'h0007);
    srch(T_BOOL, C_EQ, 16'h0000, 16'h0005);
    $display("search tests done");
    wrap_up();
  end
endmodule
